// file: hw/twu_master.v
// Two-wire unit bus master: drives SCL and SDA open-drain, frames bytes.
// Assumes external pull-ups and a command source on the same clock.
`include "twu_regs.vh"

module twu_master (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       cmd_valid,
   output reg        cmd_ready_ff,
   input  wire       cmd_start,
   input  wire       cmd_stop,
   input  wire       cmd_read,
   input  wire       cmd_last,
   input  wire [7:0] cmd_data,
   output wire       rd_valid,
   input  wire       rd_ready,
   output wire [7:0] rd_data,
   output reg        done_ff,
   output reg        nack_ff,
   output reg        arb_lost_ff,
   output reg        bus_err_ff,
   output reg        busy_ff,
   input  wire       scl_i,
   output reg        scl_o_ff,
   output reg        scl_oe_n_ff,
   input  wire       sda_i,
   output reg        sda_o_ff,
   output reg        sda_oe_n_ff
);
   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_START  = 3'h1;
   localparam [2:0] S_BIT    = 3'h2;
   localparam [2:0] S_WAIT   = 3'h3;
   localparam [2:0] S_RSTART = 3'h4;
   localparam [2:0] S_STOP   = 3'h5;
   localparam integer QTR_LAST = `TWU_QTR_CYC - 1;
   localparam integer FREE_CYC = `TWU_FREE_CYC;

   reg  [2:0] state_ff;
   reg  [1:0] ph_ff;
   reg  [3:0] bit_ff;
   reg  [7:0] sh_ff;
   reg        rd_mode_ff;
   reg        last_ff;
   reg  [7:0] div_ff;
   reg        tick_ff;
   reg        scl_m_ff, scl_s_ff, scl_q_ff;
   reg        sda_m_ff, sda_s_ff, sda_q_ff;
   reg  [7:0] free_ff;
   reg        stop_seen_ff;
   reg        push_ff;
   reg  [7:0] push_data_ff;
   wire       buf_ready;
   wire       start_det;
   wire       stop_det;
   wire       take;

   // ------------------------------------------------------------------
   // Line synchronisers and condition detection
   // ------------------------------------------------------------------
   // Two flops per line, third flop holds the previous settled level
   always @(posedge clk) begin
      if (sys_rst) begin
         scl_m_ff <= 1'b1;
         scl_s_ff <= 1'b1;
         scl_q_ff <= 1'b1;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_m_ff <= scl_i;
         scl_s_ff <= scl_m_ff;
         scl_q_ff <= scl_s_ff;
         sda_m_ff <= sda_i;
         sda_s_ff <= sda_m_ff;
         sda_q_ff <= sda_s_ff;
      end
   end

   // SDA edges while SCL stays high
   assign start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
   assign stop_det  = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;

   // Bus busy from any Start until the free time after a Stop
   always @(posedge clk) begin
      if (sys_rst) begin
         busy_ff      <= 1'b0;
         stop_seen_ff <= 1'b0;
         free_ff      <= 8'h00;
      end else if (start_det) begin
         busy_ff      <= 1'b1;
         stop_seen_ff <= 1'b0;
      end else if (stop_det) begin
         stop_seen_ff <= 1'b1;
         free_ff      <= 8'h00;
      end else if (stop_seen_ff) begin
         if (free_ff == FREE_CYC[7:0]) begin
            busy_ff      <= 1'b0;
            stop_seen_ff <= 1'b0;
         end else begin
            free_ff <= free_ff + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // Quarter-period enable divider
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst || state_ff == S_IDLE) begin
         div_ff  <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (div_ff == QTR_LAST[7:0]);
         div_ff  <= (div_ff == QTR_LAST[7:0]) ? 8'h00 : div_ff + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Receive buffer
   // ------------------------------------------------------------------
   twu_buf u_buf (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .in_valid     (push_ff),
      .in_ready     (buf_ready),
      .in_data      (push_data_ff),
      .out_valid_ff (rd_valid),
      .out_ready    (rd_ready),
      .out_data_ff  (rd_data)
   );

   assign take = cmd_valid & cmd_ready_ff;

   // ------------------------------------------------------------------
   // Bus sequencer
   // ------------------------------------------------------------------
   // Lines are released in idle; a slave may hold SCL low to stretch the clock
   always @(posedge clk) begin
      if (sys_rst) begin
         state_ff     <= S_IDLE;
         ph_ff        <= 2'h0;
         bit_ff       <= 4'h0;
         sh_ff        <= 8'h00;
         rd_mode_ff   <= 1'b0;
         last_ff      <= 1'b0;
         cmd_ready_ff <= 1'b0;
         done_ff      <= 1'b0;
         nack_ff      <= 1'b0;
         arb_lost_ff  <= 1'b0;
         bus_err_ff   <= 1'b0;
         push_ff      <= 1'b0;
         push_data_ff <= 8'h00;
         scl_o_ff     <= 1'b0;
         scl_oe_n_ff  <= 1'b1;
         sda_o_ff     <= 1'b0;
         sda_oe_n_ff  <= 1'b1;
      end else begin
         done_ff      <= 1'b0;
         arb_lost_ff  <= 1'b0;
         bus_err_ff   <= 1'b0;
         push_ff      <= 1'b0;
         cmd_ready_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               scl_oe_n_ff  <= 1'b1;
               sda_oe_n_ff  <= 1'b1;
               cmd_ready_ff <= ~take & ~busy_ff & scl_s_ff & sda_s_ff & buf_ready;
               if (take) begin
                  done_ff <= ~cmd_start; // Lone Stop or byte without Start dropped
                  if (cmd_start) begin
                     state_ff   <= S_START;
                     ph_ff      <= 2'h0;
                     sh_ff      <= cmd_data;
                     rd_mode_ff <= 1'b0;
                  end
               end
            end
            S_START: begin
               if (tick_ff) begin
                  ph_ff <= ph_ff + 2'h1;
                  if (ph_ff == 2'h0) begin
                     sda_oe_n_ff <= 1'b0;
                  end else begin
                     scl_oe_n_ff <= 1'b0;
                     state_ff    <= S_BIT;
                     ph_ff       <= 2'h0;
                     bit_ff      <= 4'h0;
                  end
               end
            end
            S_BIT: begin
               if (start_det || stop_det) begin
                  state_ff    <= S_IDLE;
                  bus_err_ff  <= 1'b1;
                  scl_oe_n_ff <= 1'b1;
                  sda_oe_n_ff <= 1'b1;
               end else if (ph_ff == 2'h0) begin
                  if (tick_ff) begin
                     // Data set up with SCL low
                     if (bit_ff == `TWU_ACK_IDX)
                        sda_oe_n_ff <= ~(rd_mode_ff & ~last_ff);
                     else
                        sda_oe_n_ff <= rd_mode_ff | sh_ff[7];
                     ph_ff <= 2'h1;
                  end
               end else if (ph_ff == 2'h1) begin
                  if (tick_ff) begin
                     scl_oe_n_ff <= 1'b1;
                     ph_ff       <= 2'h2;
                  end
               end else if (ph_ff == 2'h2) begin
                  if (tick_ff && scl_s_ff) begin
                     ph_ff <= 2'h3;
                     if (bit_ff != `TWU_ACK_IDX) begin
                        sh_ff <= {sh_ff[6:0], sda_s_ff};
                        if (~rd_mode_ff & sh_ff[7] & ~sda_s_ff) begin
                           state_ff    <= S_IDLE;
                           arb_lost_ff <= 1'b1;
                           scl_oe_n_ff <= 1'b1;
                           sda_oe_n_ff <= 1'b1;
                        end
                     end else if (~rd_mode_ff) begin
                        nack_ff <= sda_s_ff;
                     end
                  end
               end else begin
                  if (tick_ff || ~scl_s_ff) begin
                     scl_oe_n_ff <= 1'b0;
                     ph_ff       <= 2'h0;
                     bit_ff      <= bit_ff + 4'h1;
                     if (bit_ff == `TWU_ACK_IDX) begin
                        state_ff     <= S_WAIT;
                        done_ff      <= 1'b1;
                        push_ff      <= rd_mode_ff;
                        push_data_ff <= sh_ff;
                     end
                  end
               end
            end
            S_WAIT: begin
               // SCL held low until the next command
               cmd_ready_ff <= ~take & buf_ready;
               if (take) begin
                  ph_ff   <= 2'h0;
                  bit_ff  <= 4'h0;
                  sh_ff   <= cmd_start ? cmd_data : (cmd_read ? 8'hff : cmd_data);
                  last_ff <= cmd_last;
                  rd_mode_ff <= cmd_read & ~cmd_start;
                  if (cmd_start)
                     state_ff <= S_RSTART;
                  else if (cmd_stop)
                     state_ff <= S_STOP;
                  else
                     state_ff <= S_BIT;
               end
            end
            S_RSTART: begin
               if (tick_ff && (ph_ff != 2'h2 || scl_s_ff)) begin
                  ph_ff <= ph_ff + 2'h1;
                  case (ph_ff)
                     2'h0: sda_oe_n_ff <= 1'b1;
                     2'h1: scl_oe_n_ff <= 1'b1;
                     2'h2: sda_oe_n_ff <= 1'b0;
                     default: begin
                        scl_oe_n_ff <= 1'b0;
                        state_ff    <= S_BIT;
                        ph_ff       <= 2'h0;
                     end
                  endcase
               end
            end
            S_STOP: begin
               if (tick_ff && (ph_ff != 2'h2 || scl_s_ff)) begin
                  ph_ff <= ph_ff + 2'h1;
                  case (ph_ff)
                     2'h0: sda_oe_n_ff <= 1'b0;
                     2'h1: scl_oe_n_ff <= 1'b1;
                     default: begin
                        sda_oe_n_ff <= 1'b1;
                        state_ff    <= S_IDLE;
                        done_ff     <= 1'b1;
                     end
                  endcase
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end
endmodule // twu_master

// file: common/twu_regs.vh
// Constants for the two-wire unit bus master: timing counts and bit layout.
// Assumes a 10 MHz system clock; all counts derive from the clock period.
`ifndef TWU_REGS_VH
`define TWU_REGS_VH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define TWU_CLK_NS     100
`define TWU_T_QTR_NS   2500
`define TWU_QTR_CYC    ((`TWU_T_QTR_NS + `TWU_CLK_NS - 1) / `TWU_CLK_NS)
`define TWU_T_FREE_NS  4700
`define TWU_FREE_CYC   ((`TWU_T_FREE_NS + `TWU_CLK_NS - 1) / `TWU_CLK_NS)

// ------------------------------------------------------------------
// Byte framing
// ------------------------------------------------------------------
`define TWU_BYTE_W     8
`define TWU_ACK_IDX    4'h8
`define TWU_DIR_READ   1'b1
`define TWU_DIR_WRITE  1'b0
`define TWU_GCALL_ADDR 8'h00

`endif

// file: hw/twu_buf.v
// Two-entry receive buffer with valid and ready on both sides.
// Assumes one clock; the head entry register drives the read data directly.
module twu_buf (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       in_valid,
   output wire       in_ready,
   input  wire [7:0] in_data,
   output reg        out_valid_ff,
   input  wire       out_ready,
   output reg  [7:0] out_data_ff
);
   reg  [1:0] count_ff;
   reg  [7:0] spare_ff;
   wire       push;
   wire       pop;
   reg  [1:0] nxt_count;

   // Handshakes on both sides
   assign in_ready = (count_ff != 2'h2);
   assign push     = in_valid & in_ready;
   assign pop      = out_valid_ff & out_ready;

   // Occupancy after this cycle
   always @* begin
      nxt_count = count_ff;
      if (push & ~pop)
         nxt_count = count_ff + 2'h1;
      else if (pop & ~push)
         nxt_count = count_ff - 2'h1;
   end

   // Head and spare entries
   always @(posedge clk) begin
      if (sys_rst) begin
         count_ff     <= 2'h0;
         spare_ff     <= 8'h00;
         out_data_ff  <= 8'h00;
         out_valid_ff <= 1'b0;
      end else begin
         count_ff     <= nxt_count;
         out_valid_ff <= (nxt_count != 2'h0);
         if (pop && count_ff == 2'h2)
            out_data_ff <= spare_ff;
         if (push) begin
            if (count_ff == 2'h0 || (count_ff == 2'h1 && pop))
               out_data_ff <= in_data;
            else
               spare_ff <= in_data;
         end
      end
   end
endmodule // twu_buf

// file: verification/twu_asserts.sv
// Port checker for the two-wire bus master, bound to its top module.
// Assumes the bench resolves both open-drain wires onto scl_i and sda_i.
module twu_asserts (
   input logic clk,
   input logic sys_rst,
   input logic cmd_valid,
   input logic cmd_ready_ff,
   input logic done_ff,
   input logic arb_lost_ff,
   input logic busy_ff,
   input logic scl_i,
   input logic sda_i,
   input logic scl_o_ff,
   input logic scl_oe_n_ff,
   input logic sda_o_ff,
   input logic sda_oe_n_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------
   // Line and handshake checks
   // --------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_reset_idle:
      assert property (disable iff (1'h0) sys_rst |=> scl_oe_n_ff && sda_oe_n_ff
         && !busy_ff && !cmd_ready_ff && !done_ff) else $error("lines not idle after reset");
   a_pins_open_drain:
      assert property (!scl_o_ff && !sda_o_ff) else $error("line driven high");
   a_ready_drop:
      assert property (cmd_valid && cmd_ready_ff |=> !cmd_ready_ff) else $error("ready held");
   a_done_single:
      assert property (done_ff |=> !done_ff) else $error("done longer than a cycle");
   a_stretch_wait:
      assert property ((scl_oe_n_ff && !scl_i) [*4] |=> scl_oe_n_ff)
         else $error("clock pulled during stretch");
   a_busy_on_start:
      assert property (scl_i && $fell(sda_i) |-> ##[1:6] busy_ff) else $error("start not busy");
   a_busy_after_stop:
      assert property (scl_i && $rose(sda_i) |-> ##8 busy_ff ##[36:52] !busy_ff)
         else $error("bus free time wrong");
   a_arb_release:
      assert property (arb_lost_ff |-> ##[0:2] scl_oe_n_ff && sda_oe_n_ff)
         else $error("lines held after arbitration loss");
endmodule // twu_asserts

bind twu_master twu_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
   .cmd_ready_ff(cmd_ready_ff), .done_ff(done_ff), .arb_lost_ff(arb_lost_ff),
   .busy_ff(busy_ff), .scl_i(scl_i), .sda_i(sda_i), .scl_o_ff(scl_o_ff),
   .scl_oe_n_ff(scl_oe_n_ff), .sda_o_ff(sda_o_ff), .sda_oe_n_ff(sda_oe_n_ff));

// file: verification/twu_slave_model.sv
// Behavioural slave device on the two-wire bus, open-drain outputs.
// Assumes pull-ups in the bench; reacts 300 ns after each clock fall.
module twu_slave_model #(
   parameter logic [6:0] OWN_ADDR = 7'h3a // Arbitrary value
) (
   input  logic       scl,
   input  logic       sda,
   input  logic [7:0] tx_byte,
   input  logic       stretch,
   input  logic       steal,
   output logic       scl_rel = 1'h1,
   output logic       sda_rel = 1'h1,
   output logic [7:0] rx_last = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   int         nbit = 0;
   logic [7:0] sh = 8'h00;
   logic       adr_ph = 1'h0, sel = 1'h0, rd = 1'h0, tx_on = 1'h0, asleep = 1'h1;
   // --------
   // Framing
   // --------
   // Start restarts the frame, Stop deselects
   always @(negedge sda) if (scl) begin
      asleep = 1'h0;
      nbit = 0;
      adr_ph = 1'h1;
      tx_on = 1'h0;
   end
   always @(posedge sda) if (scl) begin
      sel = 1'h0;
      tx_on = 1'h0;
   end
   // Sample while clock high; ack clock decides whether to keep sending
   always @(posedge scl) begin
      if (nbit == 8)
         tx_on = sel && rd && !sda;
      else
         sh = {sh[6:0], sda};
      nbit = (nbit == 8) ? 0 : nbit + 1;
   end
   // Drive data only in the low phase, optionally stretching it
   always @(negedge scl) begin
      #300;
      if (steal)
         sda_rel = 1'h0;
      else if (nbit == 8 && adr_ph) begin
         sel = !asleep && ((sh[7:1] == OWN_ADDR) || (sh == 8'h00));
         rd = sh[0];
         adr_ph = 1'h0;
         sda_rel = !sel;
      end else if (nbit == 8 && sel && !rd) begin
         rx_last = sh;
         sda_rel = 1'h0;
      end else if (tx_on && nbit < 8)
         sda_rel = tx_byte[7 - nbit];
      else
         sda_rel = 1'h1;
      if (stretch) begin
         scl_rel = 1'h0;
         #6000;
         scl_rel = 1'h1;
      end
   end
   // Stolen data line is let go when the bench says so
   always @(negedge steal) sda_rel = 1'h1;
endmodule // twu_slave_model

// file: verification/tb_top.sv
// Self-checking bench for the two-wire bus master against one slave.
// Assumes the slave model and the bound port checker.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ADDR = 7'h3a; // Arbitrary value
   localparam logic [3:0] START = 4'h8, STOP = 4'h4, WR = 4'h0, RD = 4'h2, RDL = 4'h3;
   logic       clk = 1'h0;
   logic       sys_rst = 1'h1;
   logic       cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_last, rd_ready, stretch, steal;
   logic [7:0] cmd_data, tx_byte, tx, d, rd_data, rx_last;
   logic       cmd_ready_ff, rd_valid, done_ff, nack_ff, arb_lost_ff, bus_err_ff, busy_ff;
   logic       scl_o_ff, scl_oe_n_ff, sda_o_ff, sda_oe_n_ff, scl_rel, sda_rel;
   int         fails = 0, n_tests = 0, edges = 0;
   wire        scl = scl_oe_n_ff & scl_rel;
   wire        sda = sda_oe_n_ff & sda_rel;
   // --------
   // Parts and clock
   // --------
   twu_master dut_u (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
      .cmd_ready_ff(cmd_ready_ff), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
      .cmd_read(cmd_read), .cmd_last(cmd_last), .cmd_data(cmd_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .done_ff(done_ff), .nack_ff(nack_ff),
      .arb_lost_ff(arb_lost_ff), .bus_err_ff(bus_err_ff), .busy_ff(busy_ff), .scl_i(scl),
      .scl_o_ff(scl_o_ff), .scl_oe_n_ff(scl_oe_n_ff), .sda_i(sda), .sda_o_ff(sda_o_ff),
      .sda_oe_n_ff(sda_oe_n_ff));
   twu_slave_model #(.OWN_ADDR(ADDR)) slv_u (.scl(scl), .sda(sda), .tx_byte(tx_byte),
      .stretch(stretch), .steal(steal), .scl_rel(scl_rel), .sda_rel(sda_rel),
      .rx_last(rx_last));
   always #50 clk = ~clk;
   // Count clock pulses on the wire
   always @(posedge scl) edges++;
   // --------
   // Tasks
   // --------
   task automatic tally_and_finish;
      if (fails == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'h1) begin
         fails++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic tmo(input logic hit);
      if (hit) begin
         fails++;
         $display("BAD %0t wait ran out", $time);
         tally_and_finish;
      end
   endtask
   // One command: offer, hold until taken, then wait for its end
   task automatic cmd(input logic [3:0] kind, input logic [7:0] dat, input int n_edge);
      int k;
      int e0;
      @(negedge clk);
      {cmd_start, cmd_stop, cmd_read, cmd_last} = kind;
      cmd_data = dat;
      cmd_valid = 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (cmd_ready_ff !== 1'h1 && k < 9000);
      tmo(k >= 9000);
      e0 = edges;
      @(negedge clk);
      cmd_valid = 1'h0;
      k = 0;
      while (done_ff !== 1'h1 && arb_lost_ff !== 1'h1 && bus_err_ff !== 1'h1 && k < 9000) begin
         @(posedge clk);
         #1;
         k++;
      end
      tmo(k >= 9000);
      chk(bus_err_ff === 1'h0, "transfer broken off");
      if (n_edge >= 0)
         chk(edges - e0 == n_edge, "clock pulse count");
   endtask
   task automatic pop(input logic [7:0] exp);
      int k;
      @(negedge clk);
      rd_ready = 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rd_valid !== 1'h1 && k < 100);
      tmo(k >= 100);
      chk(rd_data === exp, "read byte");
      @(negedge clk);
      rd_ready = 1'h0;
   endtask
   // --------
   // Scenarios
   // --------
   initial begin
      {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_last, rd_ready, stretch, steal} = 8'h00;
      cmd_data = 8'h00;
      tx_byte = 8'h00;
      void'($urandom(32'hed3b));
      repeat (12) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'h0;
      cmd(START, {ADDR, 1'h0}, 9);
      chk(nack_ff === 1'h0, "address refused");
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         stretch = (i == 1) | 1'($urandom);
         cmd(WR, d, 9);
         chk(rx_last === d, "written byte");
         chk(nack_ff === 1'h0, "write refused");
      end
      stretch = 1'h0;
      cmd(STOP, 8'h00, 1);
      chk(busy_ff === 1'h1, "free too early");
      cmd(START, {ADDR ^ 7'h01, 1'h0}, 9);
      chk(nack_ff === 1'h1, "foreign address taken");
      cmd(START, 8'h00, 10);
      chk(nack_ff === 1'h0, "general call refused");
      tx = 8'($urandom);
      tx_byte = tx;
      cmd(START, {ADDR, 1'h1}, 10);
      cmd(RD, 8'h00, 9);
      cmd(RD, 8'h00, 9);
      repeat (300) @(posedge clk);
      chk(cmd_ready_ff === 1'h0, "full buffer took command");
      // Master keeps its acknowledge on the wire while it stalls the clock
      chk(sda_oe_n_ff === 1'h0 && scl === 1'h0, "read byte not acknowledged");
      pop(tx);
      pop(tx);
      cmd(RDL, 8'h00, 9);
      repeat (10) @(posedge clk);
      chk(sda === 1'h1, "last byte acknowledged");
      pop(tx);
      cmd(STOP, 8'h00, 1);
      // Slave grabs the data line only once the clock is low, so no false Start
      fork
         cmd(START, 8'hff, -1);
         begin
            int w;
            w = 0;
            while (scl !== 1'h0 && w < 9000) begin
               @(negedge clk);
               w++;
            end
            tmo(w >= 9000);
            steal = 1'h1;
         end
      join
      chk(arb_lost_ff === 1'h1, "conflict missed");
      steal = 1'h0;
      repeat (100) @(posedge clk);
      chk(busy_ff === 1'h0, "bus stays busy");
      // Stop offered with no transaction open is dropped without clocks
      cmd(STOP, 8'h00, 0);
      tally_and_finish;
   end
endmodule // tb_top
